/* File: hw/mrs_pkg.sv */
/*
 Constants of the register slice logic block: sizes, APB map,
 configuration fields and selector codes.
 Assumes a 32-bit APB with byte addresses and word-aligned registers.
*/
package mrs_pkg;

   // =====================================================
   // Sizes
   localparam int NUM_IN    = 36;
   localparam int NUM_SLICE = 16;
   localparam int PT_PER    = 5;
   localparam int NUM_PT    = NUM_SLICE * PT_PER;
   localparam int NUM_GCLK  = 4;
   localparam int NUM_BCLK  = 4;
   localparam int SPAN      = 4;
   localparam int WORD_W    = 32;
   localparam int HI_W      = NUM_IN - WORD_W;
   localparam int TERM_W    = 2;
   localparam int TERM_BITS = NUM_IN * TERM_W;
   localparam int IDX_W     = 7;
   localparam int BSEL_W    = 3;

   // =====================================================
   // APB map
   localparam logic [11:0] A_CTRL  = 12'h000;
   localparam logic [11:0] A_STAT  = 12'h004;
   localparam logic [11:0] A_BCLK  = 12'h008;
   localparam logic [11:0] A_SHR   = 12'h00c;
   localparam logic [11:0] A_SLICE = 12'h040;
   localparam logic [11:0] A_TERM  = 12'h100;
   localparam logic [11:0] A_PT    = 12'h800;
   localparam logic [1:0]  TERM_WORDS = 2'h3;
   localparam logic [1:0]  W_TLO   = 2'h0;
   localparam logic [1:0]  W_THI   = 2'h1;
   localparam logic [1:0]  W_CLO   = 2'h2;
   localparam logic [1:0]  W_CHI   = 2'h3;
   localparam int CTRL_RUN = 0;
   localparam int STAT_RUN = 16;
   localparam int SHR_INIT = 0;
   localparam int SHR_CLK  = 8;

   // =====================================================
   // Slice configuration fields
   localparam int F_CLK  = 0;
   localparam int F_CE   = 3;
   localparam int F_INIT = 5;
   localparam int F_SWAP = 7;
   localparam int F_LSR  = 8;
   localparam int F_NBR  = 9;
   localparam int F_WIDE = 12;
   localparam int F_INV  = 13;
   localparam int CFG_W  = 14;

   // Roles of the cluster terms
   localparam int PT_SET = 2;
   localparam int PT_RST = 3;
   localparam int PT_CLK = 4;

   // =====================================================
   // Selector codes
   localparam logic [2:0] CK_PT  = 3'h4;
   localparam logic [2:0] CK_PTN = 3'h5;
   localparam logic [2:0] CK_SHR = 3'h6;
   localparam logic [1:0] CE_INIT  = 2'h0;
   localparam logic [1:0] CE_INITN = 2'h1;
   localparam logic [1:0] CE_SHR   = 2'h2;
   localparam logic [1:0] IN_NONE = 2'h0;
   localparam logic [1:0] IN_RST  = 2'h1;
   localparam logic [1:0] IN_SET  = 2'h2;
   localparam logic [1:0] TM_PDN  = 2'h0;
   localparam logic [1:0] TM_PUP  = 2'h1;
   localparam logic [1:0] TM_KEEP = 2'h2;
   localparam logic [1:0] TM_NONE = 2'h3;

endpackage

/* File: hw/mrs_slice_if.sv */
/*
 Signals between the logic block and one register slice.
 Assumes the block drives everything but q on the ctl side.
*/
`timescale 1ns/1ps
interface mrs_slice_if;
   logic [mrs_pkg::CFG_W-1:0]    cfg;
   logic                         sum;
   logic                         pt_set;
   logic                         pt_rst;
   logic                         pt_clk;
   logic [mrs_pkg::NUM_BCLK-1:0] bclk_pls;
   logic                         shr_lvl;
   logic                         shr_pls;
   logic                         init;
   logic                         run;
   logic                         load;
   logic                         q;

   modport ctl (output cfg, sum, pt_set, pt_rst, pt_clk, bclk_pls,
                output shr_lvl, shr_pls, init, run, load, input q);
   modport slc (input cfg, sum, pt_set, pt_rst, pt_clk, bclk_pls,
                input shr_lvl, shr_pls, init, run, load, output q);
endinterface

/* File: hw/mrs_slice.sv */
/*
 One register slice: clock select, clock enable select, set/reset.
 Assumes block and shared clocks arrive as one-cycle enables on clk_i, the term clock as a level.
*/
`timescale 1ns/1ps
module mrs_slice (
   input  wire logic clk_i,
   input  wire logic rst_i,
   mrs_slice_if.slc  port
);
   logic       q_ff;
   logic       ptclk_prev_ff;
   logic [2:0] ck;
   logic       ck_pls;
   logic       ce;
   logic       active;
   logic       eff_set;
   logic       swap;
   logic       set_c;
   logic       rst_c;
   logic       pu_val;

   // =====================================================
   // Selectors and set/reset steering
   always_comb begin
      ck = port.cfg[mrs_pkg::F_CLK +: mrs_pkg::BSEL_W];
      swap = port.cfg[mrs_pkg::F_SWAP];
      case (ck)
         mrs_pkg::CK_PT:  ck_pls = port.pt_clk & ~ptclk_prev_ff;
         mrs_pkg::CK_PTN: ck_pls = ~port.pt_clk & ptclk_prev_ff;
         mrs_pkg::CK_SHR: ck_pls = port.shr_pls;
         3'h7:            ck_pls = 1'b0;
         default:         ck_pls = port.bclk_pls[ck[1:0]];
      endcase
      case (port.cfg[mrs_pkg::F_CE +: 2])
         mrs_pkg::CE_INIT:  ce = port.init;
         mrs_pkg::CE_INITN: ce = ~port.init;
         mrs_pkg::CE_SHR:   ce = port.shr_lvl;
         default:           ce = 1'b1;
      endcase
      active = (port.cfg[mrs_pkg::F_INIT +: 2] == mrs_pkg::IN_SET) ||
               (port.cfg[mrs_pkg::F_INIT +: 2] == mrs_pkg::IN_RST);
      eff_set = (port.cfg[mrs_pkg::F_INIT +: 2] == mrs_pkg::IN_SET)
                ^ swap;
      set_c = port.init & active & eff_set;
      rst_c = port.init & active & ~eff_set;
      if (port.cfg[mrs_pkg::F_LSR]) begin
         set_c = set_c | (swap ? port.pt_rst : port.pt_set);
         rst_c = rst_c | (swap ? port.pt_set : port.pt_rst);
      end
      pu_val = active & eff_set;
   end

   // =====================================================
   // Register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_ff <= 1'b0;
      end else if (port.load) begin
         q_ff <= pu_val;
      end else if (port.run) begin
         if (rst_c) begin
            q_ff <= 1'b0;
         end else if (set_c) begin
            q_ff <= 1'b1;
         end else if (ck_pls && ce) begin
            q_ff <= port.sum ^ port.cfg[mrs_pkg::F_INV];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ptclk_prev_ff <= 1'b0;
      end else begin
         ptclk_prev_ff <= port.pt_clk;
      end
   end

   assign port.q = q_ff;
endmodule

/* File: hw/mrs_logic_block.sv */
/*
 Logic block top: APB configuration, AND array, term allocator,
 block clock generator and sixteen register slices.
 Assumes routed inputs are on clk_i and global clock pins are not.
*/
`timescale 1ns/1ps
// Functional notes
// - Clock enable from four-way selector
// - One init term reaches every slice
// - Two cluster terms give local set/reset
// - Swap exchanges set and reset, power-up too
// - Unswapped set-on-init slices power up set
// - Unconfigured or unswapped reset-on-init slices power up reset
// - Four block clocks from true/complement globals
// - Clusters of five terms per slice
// - Fast path twenty terms, wide thirty-five
// - Thirty-six inputs, sixteen identical slices
// - Per-pin termination, pull-down by default
module mrs_logic_block (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          psel_i,
   input  wire logic                          penable_i,
   input  wire logic                          pwrite_i,
   input  wire logic [11:0]                   paddr_i,
   input  wire logic [31:0]                   pwdata_i,
   output wire logic [31:0]                   prdata_o,
   output wire logic                          pready_o,
   output wire logic                          pslverr_o,
   input  wire logic [mrs_pkg::NUM_IN-1:0]    route_i,
   input  wire logic [mrs_pkg::NUM_GCLK-1:0]  gclk_i,
   output wire logic [mrs_pkg::NUM_SLICE-1:0] slice_q_o,
   output wire logic [mrs_pkg::TERM_BITS-1:0] term_sel_o
);
   // =====================================================
   // State
   logic                          pready_ff;
   logic [31:0]                   prdata_ff;
   logic                          pslverr_ff;
   logic                          run_ff;
   logic                          load_ff;
   logic [11:0]                   bclk_cfg_ff;
   logic [mrs_pkg::IDX_W-1:0]     init_idx_ff;
   logic [mrs_pkg::IDX_W-1:0]     shr_idx_ff;
   logic [mrs_pkg::CFG_W-1:0]     cfg_ff [mrs_pkg::NUM_SLICE];
   logic [mrs_pkg::TERM_BITS-1:0] term_ff;
   logic [mrs_pkg::NUM_IN-1:0]    pt_t_ff [mrs_pkg::NUM_PT];
   logic [mrs_pkg::NUM_IN-1:0]    pt_c_ff [mrs_pkg::NUM_PT];
   logic [mrs_pkg::NUM_GCLK-1:0]  g1_ff;
   logic [mrs_pkg::NUM_GCLK-1:0]  g2_ff;
   logic [mrs_pkg::NUM_GCLK-1:0]  g3_ff;
   logic [mrs_pkg::NUM_GCLK-1:0]  gclk_ff;
   logic [mrs_pkg::NUM_BCLK-1:0]  bclk_prev_ff;
   logic                          shr_prev_ff;

   // =====================================================
   // Combinational signals
   logic                          acc;
   logic                          aligned;
   logic                          wr_en;
   logic                          is_pt;
   logic                          is_slice;
   logic                          is_term;
   logic [mrs_pkg::IDX_W-1:0]     pt_idx;
   logic [1:0]                    pt_word;
   logic [3:0]                    slc_idx;
   logic [1:0]                    term_w;
   logic [31:0]                   rd_data;
   logic                          rd_err;
   logic [mrs_pkg::NUM_PT-1:0]    pt_val;
   logic [mrs_pkg::NUM_SLICE-1:0] own;
   logic [mrs_pkg::NUM_SLICE-1:0] fast;
   logic [mrs_pkg::NUM_SLICE-1:0] sum;
   logic [mrs_pkg::NUM_BCLK-1:0]  bclk_lvl;
   logic [mrs_pkg::NUM_BCLK-1:0]  bclk_pls;
   logic                          init_term;
   logic                          shr_lvl;
   logic                          shr_pls;
   logic [mrs_pkg::NUM_SLICE-1:0] slice_q;

   // =====================================================
   // APB decode
   assign acc      = psel_i & penable_i;
   assign aligned  = (paddr_i[1:0] == 2'h0);
   assign pt_idx   = paddr_i[10:4];
   assign pt_word  = paddr_i[3:2];
   assign slc_idx  = paddr_i[5:2];
   assign term_w   = paddr_i[3:2];
   assign is_pt    = aligned && paddr_i[11] &&
                     (pt_idx < mrs_pkg::IDX_W'(mrs_pkg::NUM_PT));
   assign is_slice = aligned &&
                     (paddr_i[11:6] == mrs_pkg::A_SLICE[11:6]);
   assign is_term  = aligned &&
                     (paddr_i[11:4] == mrs_pkg::A_TERM[11:4]) &&
                     (term_w < mrs_pkg::TERM_WORDS);
   assign wr_en    = acc & pready_ff & pwrite_i & ~rd_err;

   always_comb begin
      rd_data = 32'h0;
      rd_err  = 1'b0;
      if (is_pt) begin
         case (pt_word)
            mrs_pkg::W_TLO: begin
               rd_data = pt_t_ff[pt_idx][mrs_pkg::WORD_W-1:0];
            end
            mrs_pkg::W_THI: begin
               rd_data[mrs_pkg::HI_W-1:0] =
                  pt_t_ff[pt_idx][mrs_pkg::NUM_IN-1:mrs_pkg::WORD_W];
            end
            mrs_pkg::W_CLO: begin
               rd_data = pt_c_ff[pt_idx][mrs_pkg::WORD_W-1:0];
            end
            default: begin
               rd_data[mrs_pkg::HI_W-1:0] =
                  pt_c_ff[pt_idx][mrs_pkg::NUM_IN-1:mrs_pkg::WORD_W];
            end
         endcase
      end else if (is_slice) begin
         rd_data[mrs_pkg::CFG_W-1:0] = cfg_ff[slc_idx];
      end else if (is_term) begin
         for (int b = 0; b < 32; b++) begin
            if (32 * term_w + b < mrs_pkg::TERM_BITS) begin
               rd_data[b] = term_ff[32 * term_w + b];
            end
         end
      end else begin
         case (paddr_i)
            mrs_pkg::A_CTRL: begin
               rd_data[mrs_pkg::CTRL_RUN] = run_ff;
            end
            mrs_pkg::A_STAT: begin
               rd_data[mrs_pkg::NUM_SLICE-1:0] = slice_q;
               rd_data[mrs_pkg::STAT_RUN] = run_ff;
            end
            mrs_pkg::A_BCLK: begin
               rd_data[11:0] = bclk_cfg_ff;
            end
            mrs_pkg::A_SHR: begin
               rd_data[mrs_pkg::SHR_INIT +: mrs_pkg::IDX_W] = init_idx_ff;
               rd_data[mrs_pkg::SHR_CLK +: mrs_pkg::IDX_W] = shr_idx_ff;
            end
            default: begin
               rd_err = 1'b1;
            end
         endcase
      end
   end

   // =====================================================
   // APB answer: one wait state, data sampled with pready
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= acc & ~pready_ff;
         if (acc && !pready_ff) begin
            prdata_ff  <= pwrite_i ? 32'h0 : rd_data;
            pslverr_ff <= rd_err;
         end
      end
   end

   // =====================================================
   // Control and shared term selection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_ff  <= 1'b0;
         load_ff <= 1'b0;
      end else begin
         load_ff <= 1'b0;
         if (wr_en && paddr_i == mrs_pkg::A_CTRL) begin
            run_ff  <= pwdata_i[mrs_pkg::CTRL_RUN];
            load_ff <= pwdata_i[mrs_pkg::CTRL_RUN] & ~run_ff;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bclk_cfg_ff <= 12'h0;
         init_idx_ff <= 7'h0;
         shr_idx_ff  <= 7'h0;
      end else if (wr_en && paddr_i == mrs_pkg::A_BCLK) begin
         bclk_cfg_ff <= pwdata_i[11:0];
      end else if (wr_en && paddr_i == mrs_pkg::A_SHR) begin
         init_idx_ff <= pwdata_i[mrs_pkg::SHR_INIT +: mrs_pkg::IDX_W];
         shr_idx_ff  <= pwdata_i[mrs_pkg::SHR_CLK +: mrs_pkg::IDX_W];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int s = 0; s < mrs_pkg::NUM_SLICE; s++) begin
            cfg_ff[s] <= '0;
         end
      end else if (wr_en && is_slice) begin
         cfg_ff[slc_idx] <= pwdata_i[mrs_pkg::CFG_W-1:0];
      end
   end

   // =====================================================
   // Pin termination
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         term_ff <= {mrs_pkg::NUM_IN{mrs_pkg::TM_PDN}};
      end else if (wr_en && is_term) begin
         for (int b = 0; b < 32; b++) begin
            if (32 * term_w + b < mrs_pkg::TERM_BITS) begin
               term_ff[32 * term_w + b] <= pwdata_i[b];
            end
         end
      end
   end

   // =====================================================
   // AND array literals
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int p = 0; p < mrs_pkg::NUM_PT; p++) begin
            pt_t_ff[p] <= '0;
            pt_c_ff[p] <= '0;
         end
      end else if (wr_en && is_pt) begin
         case (pt_word)
            mrs_pkg::W_TLO: begin
               pt_t_ff[pt_idx][mrs_pkg::WORD_W-1:0] <= pwdata_i;
            end
            mrs_pkg::W_THI: begin
               pt_t_ff[pt_idx][mrs_pkg::NUM_IN-1:mrs_pkg::WORD_W] <=
                  pwdata_i[mrs_pkg::HI_W-1:0];
            end
            mrs_pkg::W_CLO: begin
               pt_c_ff[pt_idx][mrs_pkg::WORD_W-1:0] <= pwdata_i;
            end
            default: begin
               pt_c_ff[pt_idx][mrs_pkg::NUM_IN-1:mrs_pkg::WORD_W] <=
                  pwdata_i[mrs_pkg::HI_W-1:0];
            end
         endcase
      end
   end

   // Empty terms evaluate low
   always_comb begin
      for (int p = 0; p < mrs_pkg::NUM_PT; p++) begin
         pt_val[p] = (|(pt_t_ff[p] | pt_c_ff[p])) &&
                     (&((route_i | ~pt_t_ff[p]) &
                        (~route_i | ~pt_c_ff[p])));
      end
   end

   // =====================================================
   // Term allocator
   always_comb begin
      for (int s = 0; s < mrs_pkg::NUM_SLICE; s++) begin
         own[s] = pt_val[mrs_pkg::PT_PER * s] |
                  pt_val[mrs_pkg::PT_PER * s + 1];
         if (!cfg_ff[s][mrs_pkg::F_LSR]) begin
            own[s] = own[s] |
                     pt_val[mrs_pkg::PT_PER * s + mrs_pkg::PT_SET] |
                     pt_val[mrs_pkg::PT_PER * s + mrs_pkg::PT_RST];
         end
         if (cfg_ff[s][mrs_pkg::F_CLK +: mrs_pkg::BSEL_W] !=
                mrs_pkg::CK_PT &&
             cfg_ff[s][mrs_pkg::F_CLK +: mrs_pkg::BSEL_W] !=
                mrs_pkg::CK_PTN) begin
            own[s] = own[s] |
                     pt_val[mrs_pkg::PT_PER * s + mrs_pkg::PT_CLK];
         end
      end
      for (int s = 0; s < mrs_pkg::NUM_SLICE; s++) begin
         fast[s] = own[s];
         for (int n = 1; n < mrs_pkg::SPAN; n++) begin
            if (cfg_ff[s][mrs_pkg::F_NBR + n - 1]) begin
               fast[s] = fast[s] | own[(s + n) % mrs_pkg::NUM_SLICE];
            end
         end
      end
      for (int s = 0; s < mrs_pkg::NUM_SLICE; s++) begin
         sum[s] = fast[s];
         if (cfg_ff[s][mrs_pkg::F_WIDE]) begin
            for (int n = 1; n < mrs_pkg::SPAN; n++) begin
               sum[s] = sum[s] | fast[(s + n) % mrs_pkg::NUM_SLICE];
            end
         end
      end
   end

   // =====================================================
   // Shared init and clock terms
   assign init_term = (init_idx_ff < mrs_pkg::IDX_W'(mrs_pkg::NUM_PT)) &&
                      pt_val[init_idx_ff];
   assign shr_lvl   = (shr_idx_ff < mrs_pkg::IDX_W'(mrs_pkg::NUM_PT)) &&
                      pt_val[shr_idx_ff];
   assign shr_pls   = shr_lvl & ~shr_prev_ff;

   // =====================================================
   // Global clock pins and block clock generator
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         g1_ff   <= '0;
         g2_ff   <= '0;
         g3_ff   <= '0;
         gclk_ff <= '0;
      end else begin
         g1_ff <= gclk_i;
         g2_ff <= g1_ff;
         g3_ff <= g2_ff;
         for (int k = 0; k < mrs_pkg::NUM_GCLK; k++) begin
            if (g2_ff[k] == g3_ff[k]) begin
               gclk_ff[k] <= g3_ff[k];
            end
         end
      end
   end

   // Inverted selection turns the falling global edge into the pulse
   always_comb begin
      for (int k = 0; k < mrs_pkg::NUM_BCLK; k++) begin
         bclk_lvl[k] = gclk_ff[bclk_cfg_ff[mrs_pkg::BSEL_W * k +: 2]] ^
                       bclk_cfg_ff[mrs_pkg::BSEL_W * k + 2];
      end
   end

   assign bclk_pls = bclk_lvl & ~bclk_prev_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bclk_prev_ff <= '0;
         shr_prev_ff  <= 1'b0;
      end else begin
         bclk_prev_ff <= bclk_lvl;
         shr_prev_ff  <= shr_lvl;
      end
   end

   // =====================================================
   // Register slices
   for (genvar s = 0; s < mrs_pkg::NUM_SLICE; s++) begin : g_slice
      mrs_slice_if sif ();

      assign sif.cfg      = cfg_ff[s];
      assign sif.sum      = sum[s];
      assign sif.pt_set   = pt_val[mrs_pkg::PT_PER * s + mrs_pkg::PT_SET];
      assign sif.pt_rst   = pt_val[mrs_pkg::PT_PER * s + mrs_pkg::PT_RST];
      assign sif.pt_clk   = pt_val[mrs_pkg::PT_PER * s + mrs_pkg::PT_CLK];
      assign sif.bclk_pls = bclk_pls;
      assign sif.shr_lvl  = shr_lvl;
      assign sif.shr_pls  = shr_pls;
      assign sif.init     = init_term;
      assign sif.run      = run_ff;
      assign sif.load     = load_ff;
      assign slice_q[s]   = sif.q;

      mrs_slice u_slice (
         .clk_i (clk_i),
         .rst_i (rst_i),
         .port  (sif.slc)
      );
   end

   // =====================================================
   // Outputs
   assign prdata_o   = prdata_ff;
   assign pready_o   = pready_ff;
   assign pslverr_o  = pslverr_ff;
   assign slice_q_o  = slice_q;
   assign term_sel_o = term_ff;

endmodule

/* File: bench/mrs_logic_block_assertions.sv */
/*
 Checker of the logic block ports: APB answer and reset state.
 Assumes it is bound to every mrs_logic_block instance.
*/
`timescale 1ns/1ps
module mrs_logic_block_assertions (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [15:0] slice_q_o,
   input wire logic [71:0] term_sel_o
);
   // =====
   // Properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_access; psel_i && penable_i && !pready_o; endsequence
   sequence s_answer; pready_o ##1 !pready_o; endsequence
   property p_rdy; s_access |=> s_answer; endproperty
   property p_cause; $rose(pready_o) |-> $past(psel_i && penable_i);
   endproperty
   property p_idle; !psel_i |=> !pready_o; endproperty
   property p_err; pready_o && pslverr_o |-> prdata_o == 32'h0; endproperty
   property p_wr; pready_o && pwrite_i |-> prdata_o == 32'h0; endproperty
   property p_rst_q; $fell(rst_i) |-> slice_q_o == 16'h0; endproperty
   property p_rst_t; $fell(rst_i) |-> term_sel_o == 72'h0; endproperty
   property p_term; $changed(term_sel_o) |-> $past(pready_o && pwrite_i);
   endproperty
   property p_stat; pready_o && !pwrite_i && paddr_i == 12'h004
      |-> prdata_o[15:0] == $past(slice_q_o); endproperty
   a_rdy: assert property (p_rdy) else $error("ready late");
   a_cause: assert property (p_cause) else $error("ready uncaused");
   a_idle: assert property (p_idle) else $error("ready when idle");
   a_err: assert property (p_err) else $error("error data not 0");
   a_wr: assert property (p_wr) else $error("write data not 0");
   a_rst_q: assert property (p_rst_q) else $error("q not 0");
   a_rst_t: assert property (p_rst_t) else $error("term");
   a_term: assert property (p_term) else $error("term moved");
   a_stat: assert property (p_stat) else $error("stat q");
endmodule
bind mrs_logic_block mrs_logic_block_assertions u_chk (.clk_i(clk_i),
   .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .slice_q_o(slice_q_o),
   .term_sel_o(term_sel_o));

/* File: bench/mrs_fabric_model.sv */
/*
 Fabric model: routed inputs and global clock pins.
 Assumes one clock; pins pulse only once enabled.
*/
`timescale 1ns/1ps
module mrs_fabric_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        en_i,
   input  wire logic        pls_i,
   input  wire logic [35:0] val_i,
   output logic      [35:0] route_o,
   output wire logic [3:0]  gclk_o
);
   // =====
   // Drive
   logic [2:0] cnt = 3'h0;
   initial route_o = 36'h0;
   always @(posedge clk_i) begin
      route_o <= val_i;
      if (rst_i || !en_i) cnt <= 3'h0;
      else if (pls_i) cnt <= 3'h4;
      else if (cnt != 3'h0) cnt <= cnt - 3'h1;
   end
   assign gclk_o = {4{cnt != 3'h0}};
endmodule

/* File: bench/tb.sv */
/*
 Self-checking bench of the logic block.
 Assumes package, interface, design and bench files compile first.
*/
`timescale 1ns/1ps
module tb;
   logic        clk_i, rst_i, psel, penable, pwrite, rerr, fen, fpls;
   logic        prdy, perr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat, rng, r;
   logic [35:0] fval, route;
   logic [3:0]  gclk;
   logic [15:0] q, eq;
   logic [71:0] term;
   logic [95:0] tv;
   logic [1:0]  md [16];
   logic        sw [16];
   int          fails, tests_run, i;

   mrs_logic_block u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy),
      .pslverr_o(perr), .route_i(route), .gclk_i(gclk),
      .slice_q_o(q), .term_sel_o(term));
   mrs_fabric_model u_fab (.clk_i(clk_i), .rst_i(rst_i), .en_i(fen),
      .pls_i(fpls), .val_i(fval), .route_o(route), .gclk_o(gclk));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // =====
   // Helpers
   function automatic logic [31:0] nxt();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic pu(logic [1:0] m, logic s);
      return (m == 2'h0) ? 1'b0 : ((m == 2'h2) ^ s);
   endfunction
   task automatic give_verdict();
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [87:0] g, input logic [87:0] e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (prdy !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = perr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
      if (n == 20) begin
         fails++;
         give_verdict();
      end
   endtask
   task automatic waitq(input logic [15:0] e);
      int n;
      n = 0;
      while (q !== e && n < 12) begin
         @(posedge clk_i);
         n++;
      end
      chk(88'(q), 88'(e));
      if (q !== e) give_verdict();
   endtask
   // Route value v, then k picks the expected slice reaction
   task automatic step(input logic [35:0] v, input int k);
      fval <= v;
      for (int s = 0; s < 16; s++)
         eq[s] = k == 0 ? !sw[s] : k == 1 ? 1'b0 : k == 2 ? sw[s] :
                 md[s] == 2'h0 ? eq[s] : pu(md[s], sw[s]);
      waitq(eq);
   endtask
   task automatic pulse();
      fpls <= 1'b1;
      @(posedge clk_i);
      fpls <= 1'b0;
      repeat (12) @(posedge clk_i);
   endtask

   // =====
   // Sequence
   initial begin
      rng = 32'd57993;
      fails = 0;
      tests_run = 0;
      rst_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      fen = 1'b0;
      fpls = 1'b0;
      fval = 36'h0;
      repeat (8) @(posedge clk_i);
      chk({q, term}, 88'h0);
      rst_i <= 1'b0;
      for (i = 0; i < 3; i++) begin
         tv[32*i +: 32] = nxt();
         apb(1'b1, 12'h100 + 12'(4 * i), tv[32*i +: 32]);
      end
      chk(88'(term), 88'(tv[71:0]));
      apb(1'b1, 12'h101, 32'h0);
      chk(88'({rerr, term}), 88'({1'b1, tv[71:0]}));
      apb(1'b0, 12'h0f0, 32'h0);
      chk(88'({rerr, rdat}), 88'({1'b1, 32'h0}));
      $display("test termination done");
      apb(1'b1, 12'h00c, 32'h7f4b);
      apb(1'b1, 12'hcb0, 32'h1);
      for (i = 0; i < 16; i++) begin
         r = nxt();
         md[i] = 2'(r % 3);
         sw[i] = r[8];
         eq[i] = pu(md[i], sw[i]);
         apb(1'b1, 12'h800 + 12'(80 * i + 32), 32'h2);
         apb(1'b1, 12'h800 + 12'(80 * i + 48), 32'h4);
         apb(1'b1, 12'h040 + 12'(4 * i),
             32'h107 | 32'(md[i]) << 5 | 32'(sw[i]) << 7);
      end
      apb(1'b1, 12'h000, 32'h1);
      waitq(eq);
      fen <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk(88'(rdat), 88'({15'h0, 1'b1, eq}));
      $display("test power-up done");
      step(36'h2, 0);
      step(36'h6, 1);
      step(36'h4, 2);
      step(36'h1, 3);
      $display("test set reset done");
      apb(1'b1, 12'h800, 32'h20);
      apb(1'b1, 12'h040, 32'h18);
      apb(1'b1, 12'h008, 32'h0);
      fval <= 36'h20;
      pulse();
      eq[0] = 1'b1;
      chk(88'(q), 88'(eq));
      apb(1'b1, 12'h040, 32'h0);
      fval <= 36'h0;
      pulse();
      chk(88'(q), 88'(eq));
      apb(1'b1, 12'h040, 32'h8);
      pulse();
      eq[0] = 1'b0;
      chk(88'(q), 88'(eq));
      apb(1'b1, 12'h008, 32'h4);
      fval <= 36'h20;
      pulse();
      eq[0] = 1'b1;
      chk(88'(q), 88'(eq));
      // Neighbour cluster through the fast path, inverted D
      apb(1'b1, 12'h850, 32'h40);
      apb(1'b1, 12'h040, 32'h2218);
      fval <= 36'h40;
      pulse();
      eq[0] = 1'b0;
      chk(88'(q), 88'(eq));
      // Wide path gathers the neighbour's fast path
      apb(1'b1, 12'h040, 32'h1018);
      pulse();
      eq[0] = 1'b1;
      chk(88'(q), 88'(eq));
      $display("test clocks done");
      give_verdict();
   end
endmodule
